// ===== hw/cp_debug_regs.vh
// register offsets, field positions and timing constants of the
// content-protection debug/status bank; definitions only
`ifndef CP_DEBUG_REGS_VH
`define CP_DEBUG_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_DEBUG        8'hc0
`define OFS_DEBUG_TWO    8'hc1
`define OFS_STATUS       8'hc4
`define OFS_IRQ_STATUS   8'hc5
`define OFS_IRQ_MASK     8'hc6

// ----------------------------------------------------------------
// debug register fields (mirrored from the remote transmitter)
// ----------------------------------------------------------------
`define DBG_I2C_TO_DIS   6
`define DBG_CHK_EN       3
`define DBG_FAST_LINK_VERIFY      2
`define DBG_TIMER_SPEEDUP  1
`define DBG_I2C_FAST     0
`define DBG_RW_MASK      8'h4f

// ----------------------------------------------------------------
// second debug register and status fields
// ----------------------------------------------------------------
`define DBG2_NO_DECRYPT  1
`define DBG2_EN_MODE     0
`define DBG2_RESET       8'h00
`define STS_CHK_ERR      1
`define STS_AUTH_COMPLETE       0
`define STS_RESET        8'h00

// ----------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------
`define IRQ_CHK_ERR      0
`define IRQ_AUTH_DONE    1
`define IRQ_AUTH_LOST    2
`define IRQ_WIDTH        3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ          200
`define I2C_TIMEOUT_MS   1000
`define FRAME_CHK_FAST   8'h02
`define LINK_CHK_FAST    8'h10
`define FRAME_CHK_SLOW   8'h10
`define LINK_CHK_SLOW    8'h80
`define FRAME_CNT_W      7

`endif

// ===== hw/line_checksum_lane.v
// one colour lane: ones-complement running sum of 8-bit samples
// assumes add and clear strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
module line_checksum_lane (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // sample stream
  input  wire       add_en,
  input  wire       clr,
  input  wire [7:0] sample,
  // running sum
  output reg  [7:0] sum_q
);

  wire [8:0] raw_sum;
  wire [7:0] sum_d;

  // end-around carry makes it a ones-complement sum
  assign raw_sum = {1'b0, sum_q} + {1'b0, sample};
  assign sum_d   = raw_sum[7:0] + {7'h00, raw_sum[8]};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_q <= 8'h00;
    end else if (clr) begin
      sum_q <= 8'h00;
    end else if (add_en) begin
      sum_q <= sum_d;
    end
  end

endmodule

// ===== hw/content_protection_debug_status.v
// debug, control and status registers of the protection receiver
// assumes synchronous inputs, one-cycle pulses for every event
//
// How it works
// - timeout-disable debug bit stops the I2C idle timeout
// - with timeout on, bus counts as free after 1 s silence
// - when enabled, each lane's ones-complement checksum follows every line
// - fast verify: frame check every 2, link check every 16 frames
// - slow verify: frame check every 16, link check every 128 frames
// - timer-speedup bit runs authentication timers in test mode
// - fast bit selects Fast-mode I2C timing, else Standard-mode
// - debug register is read-only, mirrored from remote transmitter
// - no-decrypt bit puts encrypted pixels on the colour outputs
// - no-decrypt leaves authentication and link checks untouched
// - policy 1: skip re-enable if attached transmitter already enabled
// - policy 0: always re-enable attached transmitter at auth start
// - checksum mismatch sets the checksum error status flag
// - a write to the status register clears the checksum error unless a mismatch sets it in the same cycle
// - authenticated flag sets on successful authentication
// - authenticated flag clears on loss or restart
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "cp_debug_regs.vh"
module content_protection_debug_status #(
  parameter [31:0] TIMEOUT_CYCLES = `I2C_TIMEOUT_MS * 1000 * `CLK_MHZ
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // debug settings arriving from the remote transmitter
  input  wire        remote_debug_valid,
  input  wire [7:0]  remote_debug_value,
  // video in
  input  wire        pix_valid,
  input  wire [23:0] pix_decrypted,
  input  wire [23:0] pix_encrypted,
  input  wire        line_end,
  input  wire        line_sum_valid,
  input  wire [23:0] line_sum_data,
  input  wire        frame_start,
  // video out
  output reg         rgb_valid,
  output reg  [23:0] rgb_out,
  // link verification strobes
  output reg         frame_check_strobe,
  output reg         link_check_strobe,
  // protection I2C controller
  input  wire        i2c_bus_activity,
  output reg         i2c_bus_free,
  output reg         i2c_fast_timing,
  output reg         timer_speedup,
  // authentication engine
  input  wire        auth_start,
  input  wire        auth_success,
  input  wire        auth_lost,
  input  wire        downstream_enabled,
  output reg         downstream_enable_req,
  // interrupt
  output reg         irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function [`FRAME_CNT_W-1:0] period_mask;
    input [7:0] period;
    begin
      period_mask = period[`FRAME_CNT_W-1:0] - 7'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]            debug_q;
  reg  [7:0]            debug_two_q;
  reg                   chk_err_q;
  reg                   auth_complete_q;
  reg  [`IRQ_WIDTH-1:0] irq_status_q;
  reg  [`IRQ_WIDTH-1:0] irq_mask_q;
  reg  [`IRQ_WIDTH-1:0] irq_status_d;
  reg  [7:0]            rdata_d;

  wire wr_debug_two  = reg_wr & hit(reg_addr, `OFS_DEBUG_TWO);
  wire wr_status     = reg_wr & hit(reg_addr, `OFS_STATUS);
  wire wr_irq_status = reg_wr & hit(reg_addr, `OFS_IRQ_STATUS);
  wire wr_irq_mask   = reg_wr & hit(reg_addr, `OFS_IRQ_MASK);

  wire line_checksum_enable = debug_q[`DBG_CHK_EN];
  wire fast_link_verify     = debug_q[`DBG_FAST_LINK_VERIFY];
  wire i2c_timeout_disable  = debug_q[`DBG_I2C_TO_DIS];
  wire no_decrypt           = debug_two_q[`DBG2_NO_DECRYPT];
  wire reenable_policy      = debug_two_q[`DBG2_EN_MODE];

  // local writes to 0xc0 are ignored
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_q <= 8'h00;
    end else if (remote_debug_valid) begin
      debug_q <= remote_debug_value & `DBG_RW_MASK;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_two_q <= `DBG2_RESET;
    end else if (wr_debug_two) begin
      debug_two_q <= {6'h00, reg_wdata[`DBG2_NO_DECRYPT],
                      reg_wdata[`DBG2_EN_MODE]};
    end
  end

  // ----------------------------------------------------------------
  // line checksum lanes
  // ----------------------------------------------------------------
  wire [23:0] lane_sum;
  wire        sample_add = pix_valid & line_checksum_enable;
  reg         chk_mismatch;
  integer     k;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : lanes
      line_checksum_lane u_lane (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .add_en  (sample_add),
        .clr     (line_sum_valid),
        .sample  (pix_decrypted[8*g+7:8*g]),
        .sum_q   (lane_sum[8*g+7:8*g])
      );
    end
  endgenerate

  // transmitted value is the complement of the lane sum
  always @* begin
    chk_mismatch = 1'b0;
    for (k = 0; k < 24; k = k + 8) begin
      if (line_sum_data[k+:8] != ~lane_sum[k+:8]) begin
        chk_mismatch = 1'b1;
      end
    end
  end

  wire chk_err_event = line_sum_valid & line_checksum_enable & chk_mismatch;

  // set wins over the clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_err_q <= 1'b0;
    end else if (chk_err_event) begin
      chk_err_q <= 1'b1;
    end else if (wr_status) begin
      chk_err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // authentication status and repeater policy
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auth_complete_q <= 1'b0;
    end else if (auth_lost | auth_start) begin
      auth_complete_q <= 1'b0;
    end else if (auth_success) begin
      auth_complete_q <= 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      downstream_enable_req <= 1'b0;
    end else begin
      downstream_enable_req <= auth_start &
                               ~(reenable_policy & downstream_enabled);
    end
  end

  // ----------------------------------------------------------------
  // video output
  // ----------------------------------------------------------------
  // only the pixel mux depends on no-decrypt
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rgb_valid <= 1'b0;
      rgb_out   <= 24'h00_0000;
    end else begin
      rgb_valid <= pix_valid;
      if (pix_valid) begin
        rgb_out <= no_decrypt ? pix_encrypted : pix_decrypted;
      end
    end
  end

  // ----------------------------------------------------------------
  // link verification cadence
  // ----------------------------------------------------------------
  reg  [`FRAME_CNT_W-1:0] frame_cnt_q;
  wire [`FRAME_CNT_W-1:0] frame_mask =
    fast_link_verify ? period_mask(`FRAME_CHK_FAST)
                     : period_mask(`FRAME_CHK_SLOW);
  wire [`FRAME_CNT_W-1:0] link_mask =
    fast_link_verify ? period_mask(`LINK_CHK_FAST)
                     : period_mask(`LINK_CHK_SLOW);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_q        <= {`FRAME_CNT_W{1'b0}};
      frame_check_strobe <= 1'b0;
      link_check_strobe  <= 1'b0;
    end else begin
      frame_check_strobe <= 1'b0;
      link_check_strobe  <= 1'b0;
      if (frame_start) begin
        frame_cnt_q <= frame_cnt_q + 7'h01;
        frame_check_strobe <= (frame_cnt_q & frame_mask) == 7'h00;
        link_check_strobe  <= (frame_cnt_q & link_mask) == 7'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // protection I2C controller settings and idle timeout
  // ----------------------------------------------------------------
  localparam ST_BUSY = 2'b01;
  localparam ST_FREE = 2'b10;

  reg [1:0]  bus_state_q;
  reg [1:0]  bus_state_d;
  reg [31:0] idle_cnt_q;
  wire       idle_expired = idle_cnt_q >= TIMEOUT_CYCLES;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 32'h0000_0000;
    end else if (i2c_bus_activity | i2c_timeout_disable) begin
      idle_cnt_q <= 32'h0000_0000;
    end else if (!idle_expired) begin
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end
  end

  always @* begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      ST_BUSY: begin
        if (!i2c_timeout_disable && idle_expired) begin
          bus_state_d = ST_FREE;
        end
      end
      ST_FREE: begin
        if (i2c_bus_activity || i2c_timeout_disable) begin
          bus_state_d = ST_BUSY;
        end
      end
      default: bus_state_d = ST_BUSY;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q     <= ST_BUSY;
      i2c_bus_free    <= 1'b0;
      i2c_fast_timing <= 1'b0;
      timer_speedup   <= 1'b0;
    end else begin
      bus_state_q     <= bus_state_d;
      i2c_bus_free    <= bus_state_d == ST_FREE;
      i2c_fast_timing <= debug_q[`DBG_I2C_FAST];
      timer_speedup   <= debug_q[`DBG_TIMER_SPEEDUP];
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  wire auth_done_event = auth_success & ~auth_complete_q
                         & ~auth_lost & ~auth_start;
  wire auth_lost_event = auth_lost & auth_complete_q;

  always @* begin
    irq_status_d = irq_status_q;
    if (wr_irq_status) begin
      irq_status_d = irq_status_q & ~reg_wdata[`IRQ_WIDTH-1:0];
    end
    if (chk_err_event) begin
      irq_status_d[`IRQ_CHK_ERR] = 1'b1;
    end
    if (auth_done_event) begin
      irq_status_d[`IRQ_AUTH_DONE] = 1'b1;
    end
    if (auth_lost_event) begin
      irq_status_d[`IRQ_AUTH_LOST] = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= {`IRQ_WIDTH{1'b0}};
      irq_mask_q   <= {`IRQ_WIDTH{1'b0}};
      irq          <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata[`IRQ_WIDTH-1:0];
      end
      irq <= |(irq_status_d & (wr_irq_mask ? reg_wdata[`IRQ_WIDTH-1:0]
                                           : irq_mask_q));
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 8'h00;
    if (hit(reg_addr, `OFS_DEBUG)) begin
      rdata_d = debug_q;
    end else if (hit(reg_addr, `OFS_DEBUG_TWO)) begin
      rdata_d = debug_two_q;
    end else if (hit(reg_addr, `OFS_STATUS)) begin
      rdata_d[`STS_CHK_ERR] = chk_err_q;
      rdata_d[`STS_AUTH_COMPLETE]  = auth_complete_q;
    end else if (hit(reg_addr, `OFS_IRQ_STATUS)) begin
      rdata_d = {5'h00, irq_status_q};
    end else if (hit(reg_addr, `OFS_IRQ_MASK)) begin
      rdata_d = {5'h00, irq_mask_q};
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ===== tb/cp_far_end.sv
// far-end transmitter model: debug byte, pixels, line sums, frames
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module cp_far_end (
  // clock
  input  wire        sys_clk,
  // towards the receiver
  output reg         remote_debug_valid = 1'b0,
  output reg  [7:0]  remote_debug_value = 8'h00,
  output reg         pix_valid          = 1'b0,
  output reg  [23:0] pix_decrypted      = 24'h00_0000,
  output reg  [23:0] pix_encrypted      = 24'h00_0000,
  output reg         line_end           = 1'b0,
  output reg         line_sum_valid     = 1'b0,
  output reg  [23:0] line_sum_data      = 24'h00_0000,
  output reg         frame_start        = 1'b0
);
  task send_debug(input [7:0] v);
    @(posedge sys_clk);
    remote_debug_valid <= 1'b1;
    remote_debug_value <= v;
    @(posedge sys_clk);
    remote_debug_valid <= 1'b0;
    remote_debug_value <= ~v;
  endtask
  task send_pix(input [23:0] d, input [23:0] e);
    @(posedge sys_clk);
    pix_valid     <= 1'b1;
    pix_decrypted <= d;
    pix_encrypted <= e;
    @(posedge sys_clk);
    pix_valid     <= 1'b0;
    pix_decrypted <= ~d;
    pix_encrypted <= ~e;
  endtask
  task send_line(input integer n, input bit bad);
    reg [8:0]  s [0:2];
    reg [23:0] p;
    integer    i;
    integer    k;
    for (k = 0; k < 3; k++) s[k] = 9'h000;
    for (i = 0; i < n; i++) begin
      p = 24'($urandom);
      for (k = 0; k < 3; k++) begin
        s[k] = s[k] + p[8*k +: 8];
        s[k] = s[k][7:0] + s[k][8];
      end
      send_pix(p, ~p);
    end
    // sums go out complemented; bad spoils lane 0
    @(posedge sys_clk);
    line_end       <= 1'b1;
    line_sum_valid <= 1'b1;
    line_sum_data  <= ~{s[2][7:0], s[1][7:0], s[0][7:0]} ^ {23'h0, bad};
    @(posedge sys_clk);
    line_end       <= 1'b0;
    line_sum_valid <= 1'b0;
    line_sum_data  <= ~line_sum_data;
  endtask
  task send_frames(input integer n);
    repeat (n) begin
      @(posedge sys_clk);
      frame_start <= 1'b1;
      @(posedge sys_clk);
      frame_start <= 1'b0;
    end
  endtask
endmodule

// ===== tb/cp_debug_monitor.sv
// checker on the protection debug/status bank ports
// assumes binding to content_protection_debug_status below
`timescale 1ns/1ps
module cp_debug_monitor #(
  parameter [31:0] TIMEOUT_CYCLES = 50
) (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // observed ports
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        remote_debug_valid,
  input wire [7:0]  remote_debug_value,
  input wire        pix_valid,
  input wire        rgb_valid,
  input wire        frame_start,
  input wire        frame_check_strobe,
  input wire        i2c_bus_activity,
  input wire        i2c_bus_free,
  input wire        i2c_fast_timing,
  input wire        timer_speedup,
  input wire        auth_start,
  input wire        downstream_enabled,
  input wire        downstream_enable_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reg [7:0] mirror_q;
  reg       dis_q;
  reg [7:0] idle_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mirror_q <= 8'h00;
      dis_q    <= 1'b0;
      idle_q   <= 8'h00;
    end else begin
      if (remote_debug_valid) begin
        mirror_q <= remote_debug_value & 8'h4f;
        dis_q    <= remote_debug_value[6];
      end
      if (i2c_bus_activity || dis_q || remote_debug_valid)
        idle_q <= 8'h00;
      else if (idle_q != 8'hff)
        idle_q <= idle_q + 8'h01;
    end
  end
  property p_mirror;
    reg_rd && reg_addr == 8'hc0 |=> reg_rdata == $past(mirror_q);
  endproperty
  property p_fast;
    remote_debug_valid |->
      ##2 i2c_fast_timing == $past(remote_debug_value[0], 2);
  endproperty
  property p_speed;
    remote_debug_valid |->
      ##2 timer_speedup == $past(remote_debug_value[1], 2);
  endproperty
  property p_idle; idle_q >= TIMEOUT_CYCLES + 4 |-> i2c_bus_free; endproperty
  property p_nofree;
    dis_q && $past(dis_q) && $past(dis_q, 2) |-> !i2c_bus_free;
  endproperty
  property p_frame; frame_check_strobe |-> $past(frame_start); endproperty
  property p_req;
    auth_start && !downstream_enabled |=> downstream_enable_req;
  endproperty
  property p_cause; downstream_enable_req |-> $past(auth_start); endproperty
  property p_pix; pix_valid |=> rgb_valid; endproperty
  a_mirror: assert property (p_mirror)
    else $error("debug readback wrong");
  a_fast: assert property (p_fast)
    else $error("fast timing select wrong");
  a_speed: assert property (p_speed)
    else $error("timer speedup wrong");
  a_idle: assert property (p_idle)
    else $error("bus not free after idle");
  a_nofree: assert property (p_nofree)
    else $error("bus free while timeout off");
  a_frame: assert property (p_frame)
    else $error("frame strobe without frame");
  a_req: assert property (p_req)
    else $error("re-enable missing");
  a_cause: assert property (p_cause)
    else $error("re-enable without start");
  a_pix: assert property (p_pix)
    else $error("pixel not passed");
  c_free: cover property (i2c_bus_free);
  c_req: cover property (downstream_enable_req);
  c_frame: cover property (frame_check_strobe);
endmodule
bind content_protection_debug_status cp_debug_monitor
  #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (.*);

// ===== tb/testbench.sv
// self-checking bench for the protection debug/status bank
// assumes cp_far_end and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
  reg         sys_clk            = 1'b0;
  reg         rst_n              = 1'b0;
  reg  [7:0]  reg_addr           = 8'h00;
  reg  [7:0]  reg_wdata          = 8'h00;
  reg         reg_wr             = 1'b0;
  reg         reg_rd             = 1'b0;
  reg         i2c_bus_activity   = 1'b1;
  reg         auth_start         = 1'b0;
  reg         auth_success       = 1'b0;
  reg         auth_lost          = 1'b0;
  reg         downstream_enabled = 1'b0;
  wire [7:0]  reg_rdata, remote_debug_value;
  wire [23:0] pix_decrypted, pix_encrypted, line_sum_data, rgb_out;
  wire        remote_debug_valid, pix_valid, line_end, line_sum_valid;
  wire        frame_start, rgb_valid, frame_check_strobe, irq;
  wire        link_check_strobe, i2c_bus_free, i2c_fast_timing;
  wire        timer_speedup, downstream_enable_req;
  integer     n_mismatch = 0;
  integer     checks     = 0;
  integer     nf = 0, nl = 0, ef = 0, el = 0, i, v;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rst_n) begin
      nf = nf + frame_check_strobe;
      nl = nl + link_check_strobe;
    end
  end
  content_protection_debug_status #(.TIMEOUT_CYCLES(50))
    content_protection_debug_status_inst (.*);
  cp_far_end far_end (.*);
  task test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cmp(input [23:0] got, input [23:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  // {lost, success, start}
  task auth(input [2:0] w);
    @(posedge sys_clk);
    auth_lost    <= w[2];
    auth_success <= w[1];
    auth_start   <= w[0];
    @(posedge sys_clk);
    auth_lost    <= 1'b0;
    auth_success <= 1'b0;
    auth_start   <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    v = $urandom(8545);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'hc0, 8'h00);
    wr(8'hc0, 8'hff);
    rd(8'hc0, 8'h00);
    rd(8'hc1, 8'h00);
    rd(8'hc4, 8'h00);
    rd(8'h10, 8'h00);
    v = $urandom;
    far_end.send_debug(v[7:0]);
    @(posedge sys_clk);
    #1 cmp({timer_speedup, i2c_fast_timing}, v[1:0]);
    rd(8'hc0, v[7:0] & 8'h4f);
    for (i = 0; i < 160; i++) begin
      ef = ef + (i % (i < 32 ? 2 : 16) == 0);
      el = el + (i % (i < 32 ? 16 : 128) == 0);
    end
    far_end.send_debug(8'h04);
    far_end.send_frames(32);
    far_end.send_debug(8'h00);
    far_end.send_frames(128);
    repeat (2) @(posedge sys_clk);
    cmp(nf, ef);
    cmp(nl, el);
    for (i = 0; i < 2; i++) begin
      wr(8'hc1, {6'h0, i[0], 1'b0});
      v = $urandom;
      far_end.send_pix(v[23:0], ~v[23:0]);
      #1 cmp(rgb_out, i ? ~v[23:0] : v[23:0]);
      cmp(rgb_valid, 1'b1);
      rd(8'hc1, {6'h0, i[0], 1'b0});
    end
    far_end.send_debug(8'h08);
    for (i = 0; i < 2; i++) begin
      far_end.send_line(5, i[0]);
      rd(8'hc4, {6'h0, i[0], 1'b0});
    end
    rd(8'hc5, 8'h01);
    cmp(irq, 1'b0);
    wr(8'hc6, 8'h01);
    @(posedge sys_clk);
    #1 cmp(irq, 1'b1);
    v = $urandom;
    wr(8'hc4, v[7:0]);
    rd(8'hc4, 8'h00);
    wr(8'hc5, 8'h01);
    @(posedge sys_clk);
    #1 cmp(irq, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(8'hc1, {7'h0, i[0]});
      downstream_enabled <= i[1];
      auth(3'b001);
      #1 cmp(downstream_enable_req, !(i[0] && i[1]));
    end
    auth(3'b010);
    rd(8'hc4, 8'h01);
    auth(3'b100);
    rd(8'hc4, 8'h00);
    auth(3'b010);
    auth(3'b001);
    rd(8'hc4, 8'h00);
    rd(8'hc5, 8'h06);
    for (i = 0; i < 2; i++) begin
      far_end.send_debug({1'b0, i[0], 6'h00});
      i2c_bus_activity <= 1'b0;
      repeat (56) @(posedge sys_clk);
      #1 cmp(i2c_bus_free, !i[0]);
      @(posedge sys_clk);
      i2c_bus_activity <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 cmp(i2c_bus_free, 1'b0);
    end
    test_done;
  end
endmodule
